// *** logic/bip_pkg.sv ***
/*
  Shared constants and types of the board interrupt prioritizer: register
  offsets, reset values, source positions, timing figures and the mode enum.
  Assumes a 125 MHz pclk and an APB master with 32-bit data.
*/
`default_nettype none

package bip_pkg;

  // Clock and bus fail-safe timing
  localparam int CLK_MHZ = 125;
  localparam int FAILSAFE_TIME_US = 6000;
  localparam int FAILSAFE_CYCLES = FAILSAFE_TIME_US * CLK_MHZ;

  // Sizes
  localparam int NUM_LEVELS = 8;
  localparam int NUM_SRC = 25;
  localparam int NUM_SLAVE_SRC = 5;
  localparam int ADDR_W = 8;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_MASK = 8'h04;
  localparam logic [7:0] OFF_TRIG = 8'h08;
  localparam logic [7:0] OFF_EOI = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_POLL = 8'h14;
  localparam logic [7:0] OFF_SMASK = 8'h18;
  localparam logic [7:0] OFF_SPEND = 8'h1C;
  localparam logic [7:0] OFF_FLAGS = 8'h20;
  localparam logic [7:0] OFF_ORSEL = 8'h24;
  localparam logic [7:0] OFF_ROUTE0 = 8'h28;
  localparam logic [7:0] OFF_ROUTE3 = 8'h34;

  // Field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_LOWEST_LSB = 4;
  localparam int CTRL_VBASE_LSB = 8;
  localparam int STATUS_ISR_LSB = 8;
  localparam int STATUS_INTR_BIT = 16;
  localparam int STATUS_NMI_BIT = 17;
  localparam int POLL_VALID_BIT = 7;
  localparam int FLAG_BYTE_BIT = 0;
  localparam int FLAG_EDGE_BIT = 1;
  localparam int FLAG_FS_BIT = 2;

  // Reset values
  localparam logic [2:0] RST_LOWEST = 3'h7;
  localparam logic [7:0] RST_VBASE = 8'h20;
  localparam logic [7:0] RST_MASK = 8'hFF;
  localparam logic [7:0] RST_TRIG = 8'h00;
  localparam logic [4:0] RST_SMASK = 5'h1F;
  localparam logic [31:0] RST_ROUTE = 32'hFEDCBA98;
  localparam logic [2:0] SPURIOUS_LVL = 3'h7;

  // Positions in the 25-bit source vector
  localparam int SRC_BUS = 0;
  localparam int SRC_SERIAL = 2;
  localparam int SRC_CASCADE = 10;
  localparam int SRC_LAN = 11;
  localparam int SRC_FLAG = 12;
  localparam int SRC_SYSTICK = 13;
  localparam int SRC_EDGE = 14;
  localparam int SRC_EXP = 15;
  localparam int SRC_FAILSAFE = 19;
  localparam int SRC_ORMAT = 20;
  localparam int SRC_AUX = 21;

  typedef enum logic [1:0] {
    BIP_FULLY_NESTED,
    BIP_SPECIAL_NESTED,
    BIP_SPECIFIC,
    BIP_POLLED
  } bip_mode_t;

endpackage

`default_nettype wire

// *** logic/bip_top.sv ***
/*
  Board interrupt prioritizer: source routing, slave and master
  request_prioritizer, edge_hold_converter, OR matrix, flag byte, bus
  fail-safe timer and NMI pass-through, with an APB register slave.
  Assumes all inputs synchronous to pclk and one-cycle cpu_inta pulses.
*/
`default_nettype none

// What this block does
// - Internal controller works as slave under the master controller.
// - Slave serves only three timer and two DMA requests.
// - Master has eight inputs, each edge or level sensitive.
// - Nine levels in total; NMI is highest, wired straight to CPU.
// - Master masks and vectors the eight levels below NMI.
// - Fully nested: level 0 highest, level 7 lowest.
// - Special nested: master takes further slave requests while slave served.
// - Specific priority: software names lowest level; others follow in order.
// - Polled: poll register gives encoded highest pending request.
// - Mode and priorities can be rewritten any time without reset.
// - Requests are resolved by mode and, except in polled mode, raise the CPU interrupt.
// - Twenty-five sources, each routable to any level.
// - System bus gives two request sources.
// - Serial controller gives eight request sources.
// - Flag byte set by a bus master raises a request.
// - Fail-safe timer requests when bus handshake exceeds 6 ms.
// - Expansion connectors give four sources, two each.
// - Edge converter holds an edge as a level; one source.
// - OR matrix merges several requests into one source.
module bip_top #(
  parameter int FAILSAFE_CYCLES = bip_pkg::FAILSAFE_CYCLES,
  parameter int OR_WIDTH = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [bip_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] bus_irq,
  input wire logic [7:0] serial_irq,
  input wire logic [2:0] timer_irq,
  input wire logic [1:0] dma_irq,
  input wire logic lan_irq,
  input wire logic systick_irq,
  input wire logic [3:0] exp_irq,
  input wire logic [3:0] aux_irq,
  input wire logic edge_irq,
  input wire logic [OR_WIDTH-1:0] or_irq,
  input wire logic bus_flag_set,
  input wire logic bus_flag_clr,
  input wire logic bus_cmd_start,
  input wire logic bus_cmd_done,
  input wire logic nmi_in,
  input wire logic cpu_inta,
  output logic cpu_intr,
  output logic cpu_nmi,
  output logic [7:0] cpu_vector
);

  localparam int FS_W = $clog2(FAILSAFE_CYCLES + 1);

  // Refuse sizes the logic cannot serve
  if (FAILSAFE_CYCLES < 2 || OR_WIDTH < 1 || OR_WIDTH > 8) begin : g_chk
    $error("bip_top: unsupported parameter value");
  end

  typedef struct packed {
    bip_pkg::bip_mode_t mode;
    logic [2:0] lowest;
    logic [7:0] vbase;
    logic [7:0] mask;
    logic [7:0] trig;
    logic [7:0] irr_edge;
    logic [7:0] line_prev;
    logic [7:0] isr;
    logic [4:0] smask;
    logic [4:0] spend;
    logic [4:0] sint_prev;
    logic flag;
    logic edge_held;
    logic edge_prev;
    logic fs_flag;
    logic fs_busy;
    logic [FS_W-1:0] fs_cnt;
    logic [OR_WIDTH-1:0] orsel;
    logic [3:0][31:0] route;
    logic intr;
    logic nmi;
    logic [7:0] vector;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } bip_state_t;

  bip_state_t s_reg;
  bip_state_t s_next;

  // Priority rank of a level, 0 is served first
  function automatic logic [2:0] bip_rank(
    input logic [2:0] lvl,
    input bip_pkg::bip_mode_t mode,
    input logic [2:0] lowest
  );
    if (mode == bip_pkg::BIP_SPECIFIC) begin
      bip_rank = lvl - lowest - 3'h1;
    end else begin
      bip_rank = lvl;
    end
  endfunction

  logic [bip_pkg::NUM_SRC-1:0] src;
  logic [7:0] line;
  logic [7:0] irr;
  logic [7:0] req;
  logic req_any;
  logic [2:0] req_lvl;
  logic isr_any;
  logic [2:0] isr_lvl;
  logic [2:0] casc_lvl;
  logic casc_en;
  logic setup;
  logic access;
  logic ack;
  logic [2:0] ack_lvl;
  logic ack_valid;
  logic [3:0] rt;
  logic [2:0] rk;
  logic [31:0] rdata;
  logic rd_err;
  logic [4:0] sint;

  always_comb begin
    s_next = s_reg;
    src = '0;
    line = '0;
    irr = '0;
    req = '0;
    req_any = 1'b0;
    req_lvl = 3'h0;
    isr_any = 1'b0;
    isr_lvl = 3'h0;
    rt = 4'h0;
    rk = 3'h0;
    rdata = 32'h0000_0000;
    rd_err = 1'b0;
    ack = 1'b0;
    ack_lvl = 3'h0;
    ack_valid = 1'b0;
    setup = psel && !penable && !s_reg.pready;
    access = psel && penable && s_reg.pready;

    // Slave controller: internal timers and DMA only
    sint = {dma_irq, timer_irq};
    s_next.sint_prev = sint;

    // Source vector; slave output cascades in as one source
    src[bip_pkg::SRC_BUS +: 2] = bus_irq;
    src[bip_pkg::SRC_SERIAL +: 8] = serial_irq;
    src[bip_pkg::SRC_CASCADE] = |(s_reg.spend & ~s_reg.smask);
    src[bip_pkg::SRC_LAN] = lan_irq;
    src[bip_pkg::SRC_FLAG] = s_reg.flag;
    src[bip_pkg::SRC_SYSTICK] = systick_irq;
    src[bip_pkg::SRC_EDGE] = s_reg.edge_held;
    src[bip_pkg::SRC_EXP +: 4] = exp_irq;
    src[bip_pkg::SRC_FAILSAFE] = s_reg.fs_flag;
    src[bip_pkg::SRC_ORMAT] = |(or_irq & s_reg.orsel);
    src[bip_pkg::SRC_AUX +: 4] = aux_irq;

    // Routing matrix: {enable, level} per source
    for (int s = 0; s < bip_pkg::NUM_SRC; s++) begin
      rt = s_reg.route[s / 8][(s % 8) * 4 +: 4];
      if (rt[3] && src[s]) begin
        line[rt[2:0]] = 1'b1;
      end
    end
    rt = s_reg.route[bip_pkg::SRC_CASCADE / 8]
                    [(bip_pkg::SRC_CASCADE % 8) * 4 +: 4];
    casc_lvl = rt[2:0];
    casc_en = rt[3];

    // Request register per input: edge latch or live level
    for (int i = 0; i < bip_pkg::NUM_LEVELS; i++) begin
      irr[i] = s_reg.trig[i] ? s_reg.irr_edge[i] : line[i];
    end
    req = irr & ~s_reg.mask;

    // Highest pending request and highest level in service
    for (int i = bip_pkg::NUM_LEVELS - 1; i >= 0; i--) begin
      rk = bip_rank(3'(i), s_reg.mode, s_reg.lowest);
      if (req[i] && (!req_any ||
          rk < bip_rank(req_lvl, s_reg.mode, s_reg.lowest))) begin
        req_any = 1'b1;
        req_lvl = 3'(i);
      end
      if (s_reg.isr[i] && (!isr_any ||
          rk < bip_rank(isr_lvl, s_reg.mode, s_reg.lowest))) begin
        isr_any = 1'b1;
        isr_lvl = 3'(i);
      end
    end

    // CPU request: only above what is in service, except cascaded slave
    s_next.intr = 1'b0;
    if (s_reg.mode != bip_pkg::BIP_POLLED && req_any) begin
      if (!isr_any) begin
        s_next.intr = 1'b1;
      end else if (bip_rank(req_lvl, s_reg.mode, s_reg.lowest) <
                   bip_rank(isr_lvl, s_reg.mode, s_reg.lowest)) begin
        s_next.intr = 1'b1;
      end else if (s_reg.mode == bip_pkg::BIP_SPECIAL_NESTED &&
                   casc_en && req_lvl == casc_lvl &&
                   isr_lvl == casc_lvl) begin
        s_next.intr = 1'b1;
      end
    end

    // NMI bypasses mask and priority entirely
    s_next.nmi = nmi_in;

    // Acknowledge by CPU cycle
    if (cpu_inta && s_reg.mode != bip_pkg::BIP_POLLED) begin
      ack = 1'b1;
      ack_valid = req_any;
      ack_lvl = req_any ? req_lvl : bip_pkg::SPURIOUS_LVL;
      s_next.vector = s_reg.vbase + {5'h00, ack_lvl};
      s_next.intr = 1'b0;
    end
    // Polled read acknowledges the level it reported
    if (access && !pwrite && paddr == bip_pkg::OFF_POLL &&
        s_reg.mode == bip_pkg::BIP_POLLED) begin
      ack = s_reg.prdata[bip_pkg::POLL_VALID_BIT];
      ack_valid = ack;
      ack_lvl = s_reg.prdata[2:0];
    end

    // Edge latches; acknowledge clears, a new edge wins
    for (int i = 0; i < bip_pkg::NUM_LEVELS; i++) begin
      if (ack && ack_valid && ack_lvl == 3'(i)) begin
        s_next.irr_edge[i] = 1'b0;
        s_next.isr[i] = 1'b1;
      end
      if (line[i] && !s_reg.line_prev[i]) begin
        s_next.irr_edge[i] = 1'b1;
      end
      if (!s_reg.trig[i]) begin
        s_next.irr_edge[i] = 1'b0;
      end
    end
    s_next.line_prev = line;

    // Edge-to-level holding
    s_next.edge_prev = edge_irq;

    // Bus fail-safe timer; a new command restarts it
    if (bus_cmd_done) begin
      s_next.fs_busy = 1'b0;
      s_next.fs_cnt = '0;
    end else if (bus_cmd_start) begin
      s_next.fs_busy = 1'b1;
      s_next.fs_cnt = '0;
    end else if (s_reg.fs_busy) begin
      s_next.fs_cnt = s_reg.fs_cnt + FS_W'(1);
      if (s_reg.fs_cnt == FS_W'(FAILSAFE_CYCLES - 1)) begin
        s_next.fs_busy = 1'b0;
      end
    end

    // Read mux, sampled in the setup cycle
    if (paddr == bip_pkg::OFF_CTRL) begin
      rdata[bip_pkg::CTRL_MODE_LSB +: 2] = s_reg.mode;
      rdata[bip_pkg::CTRL_LOWEST_LSB +: 3] = s_reg.lowest;
      rdata[bip_pkg::CTRL_VBASE_LSB +: 8] = s_reg.vbase;
    end else if (paddr == bip_pkg::OFF_MASK) begin
      rdata[7:0] = s_reg.mask;
    end else if (paddr == bip_pkg::OFF_TRIG) begin
      rdata[7:0] = s_reg.trig;
    end else if (paddr == bip_pkg::OFF_EOI) begin
      rdata = 32'h0000_0000;
    end else if (paddr == bip_pkg::OFF_STATUS) begin
      rdata[7:0] = irr;
      rdata[bip_pkg::STATUS_ISR_LSB +: 8] = s_reg.isr;
      rdata[bip_pkg::STATUS_INTR_BIT] = s_reg.intr;
      rdata[bip_pkg::STATUS_NMI_BIT] = s_reg.nmi;
    end else if (paddr == bip_pkg::OFF_POLL) begin
      rdata[bip_pkg::POLL_VALID_BIT] = req_any;
      rdata[2:0] = req_lvl;
    end else if (paddr == bip_pkg::OFF_SMASK) begin
      rdata[4:0] = s_reg.smask;
    end else if (paddr == bip_pkg::OFF_SPEND) begin
      rdata[4:0] = s_reg.spend;
    end else if (paddr == bip_pkg::OFF_FLAGS) begin
      rdata[bip_pkg::FLAG_BYTE_BIT] = s_reg.flag;
      rdata[bip_pkg::FLAG_EDGE_BIT] = s_reg.edge_held;
      rdata[bip_pkg::FLAG_FS_BIT] = s_reg.fs_flag;
    end else if (paddr == bip_pkg::OFF_ORSEL) begin
      rdata[OR_WIDTH-1:0] = s_reg.orsel;
    end else if (paddr >= bip_pkg::OFF_ROUTE0 &&
                 paddr <= bip_pkg::OFF_ROUTE3 && paddr[1:0] == 2'h0) begin
      rdata = s_reg.route[2'(paddr[7:2] - bip_pkg::OFF_ROUTE0[7:2])];
    end else begin
      rd_err = 1'b1;
    end

    // APB: no wait state, answer registered at setup
    if (setup) begin
      s_next.pready = 1'b1;
      s_next.prdata = pwrite ? 32'h0000_0000 : rdata;
      s_next.pslverr = rd_err;
    end else if (s_reg.pready) begin
      s_next.pready = 1'b0;
      s_next.pslverr = 1'b0;
    end

    // Register writes take effect at the access edge
    if (access && pwrite && !s_reg.pslverr) begin
      if (paddr == bip_pkg::OFF_CTRL) begin
        s_next.mode = bip_pkg::bip_mode_t'(
          pwdata[bip_pkg::CTRL_MODE_LSB +: 2]);
        s_next.lowest = pwdata[bip_pkg::CTRL_LOWEST_LSB +: 3];
        s_next.vbase = pwdata[bip_pkg::CTRL_VBASE_LSB +: 8];
      end else if (paddr == bip_pkg::OFF_MASK) begin
        s_next.mask = pwdata[7:0];
      end else if (paddr == bip_pkg::OFF_TRIG) begin
        s_next.trig = pwdata[7:0];
      end else if (paddr == bip_pkg::OFF_EOI && isr_any) begin
        s_next.isr[isr_lvl] = 1'b0; // Non-specific end of interrupt
      end else if (paddr == bip_pkg::OFF_SMASK) begin
        s_next.smask = pwdata[4:0];
      end else if (paddr == bip_pkg::OFF_SPEND) begin
        s_next.spend = s_next.spend & ~pwdata[4:0];
      end else if (paddr == bip_pkg::OFF_FLAGS) begin
        s_next.flag = pwdata[bip_pkg::FLAG_BYTE_BIT];
        if (pwdata[bip_pkg::FLAG_EDGE_BIT]) begin
          s_next.edge_held = 1'b0;
        end
        if (pwdata[bip_pkg::FLAG_FS_BIT]) begin
          s_next.fs_flag = 1'b0;
        end
      end else if (paddr == bip_pkg::OFF_ORSEL) begin
        s_next.orsel = pwdata[OR_WIDTH-1:0];
      end else if (paddr >= bip_pkg::OFF_ROUTE0 &&
                   paddr <= bip_pkg::OFF_ROUTE3) begin
        s_next.route[2'(paddr[7:2] - bip_pkg::OFF_ROUTE0[7:2])] = pwdata;
      end
    end

    // Hardware sets come last so they win over any clear
    for (int i = 0; i < bip_pkg::NUM_SLAVE_SRC; i++) begin
      if (sint[i] && !s_reg.sint_prev[i]) begin
        s_next.spend[i] = 1'b1;
      end
    end
    if (bus_flag_clr) begin
      s_next.flag = 1'b0;
    end
    if (bus_flag_set) begin
      s_next.flag = 1'b1;
    end
    if (edge_irq && !s_reg.edge_prev) begin
      s_next.edge_held = 1'b1;
    end
    if (s_reg.fs_busy && !bus_cmd_done &&
        s_reg.fs_cnt == FS_W'(FAILSAFE_CYCLES - 1)) begin
      s_next.fs_flag = 1'b1;
    end
  end

  // State register; every output is a field of it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
      s_reg.mode <= bip_pkg::BIP_FULLY_NESTED;
      s_reg.lowest <= bip_pkg::RST_LOWEST;
      s_reg.vbase <= bip_pkg::RST_VBASE;
      s_reg.mask <= bip_pkg::RST_MASK;
      s_reg.trig <= bip_pkg::RST_TRIG;
      s_reg.smask <= bip_pkg::RST_SMASK;
      s_reg.orsel <= '1;
      s_reg.route <= {4{bip_pkg::RST_ROUTE}};
    end else begin
      s_reg <= s_next;
    end
  end

  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign cpu_intr = s_reg.intr;
  assign cpu_nmi = s_reg.nmi;
  assign cpu_vector = s_reg.vector;

endmodule // bip_top

`default_nettype wire

// *** test/bip_cpu_model.sv ***
/*
  CPU model: answers cpu_intr with a one-cycle acknowledge after a set
  delay, counting acknowledges. Assumes pclk-synchronous signals.
*/
`default_nettype none
module bip_cpu_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic en,
  input wire logic [3:0] dly,
  input wire logic cpu_intr,
  output logic cpu_inta,
  output logic [7:0] acks
);
  logic [3:0] cnt;
  // Skip the cycle after a pulse: the request is still falling then
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 4'h0;
      cpu_inta <= 1'b0;
      acks <= 8'h00;
    end else begin
      cpu_inta <= 1'b0;
      if (cpu_inta || !en || !cpu_intr) begin
        cnt <= 4'h0;
      end else if (cnt >= dly) begin
        cpu_inta <= 1'b1;
        acks <= acks + 8'h01;
        cnt <= 4'h0;
      end else begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule // bip_cpu_model
`default_nettype wire

// *** test/bip_top_chk.sv ***
/*
  Checker for bip_top: APB answer timing, error response, acknowledge,
  vector hold and NMI pass-through. Assumes binding to bip_top ports only.
*/
`default_nettype none
module bip_top_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [bip_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic nmi_in,
  input wire logic cpu_inta,
  input wire logic cpu_intr,
  input wire logic cpu_nmi,
  input wire logic [7:0] cpu_vector
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Setup cycle, then exactly one access cycle with pready
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence
  property p_answer; s_setup |=> s_answer; endproperty
  property p_ready_src; pready |-> $past(psel) && !$past(penable); endproperty
  property p_err_ready; pslverr |-> pready; endproperty
  property p_err_zero; pslverr && !pwrite |-> prdata == 32'h0; endproperty
  property p_unmapped; psel && !penable && paddr > 8'h34 |=> pslverr;
  endproperty
  property p_mapped;
    psel && !penable && paddr <= 8'h34 && paddr[1:0] == 2'h0 |=> !pslverr;
  endproperty
  // Mask and priority never touch the NMI path
  property p_nmi; $past(presetn) |-> cpu_nmi == $past(nmi_in); endproperty
  property p_ack_drop; cpu_inta |=> !cpu_intr; endproperty
  property p_vec_hold; !cpu_inta |=> $stable(cpu_vector); endproperty
  a_answer: assert property (p_answer)
    else $error("no single access cycle after setup");
  a_ready_src: assert property (p_ready_src)
    else $error("pready without a setup cycle");
  a_err_ready: assert property (p_err_ready)
    else $error("pslverr outside access cycle");
  a_err_zero: assert property (p_err_zero)
    else $error("error read data not zero");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access not refused");
  a_mapped: assert property (p_mapped)
    else $error("mapped access refused");
  a_nmi: assert property (p_nmi)
    else $error("cpu_nmi does not follow nmi_in");
  a_ack_drop: assert property (p_ack_drop)
    else $error("cpu_intr high after acknowledge");
  a_vec_hold: assert property (p_vec_hold)
    else $error("vector changed without acknowledge");
endmodule // bip_top_chk

bind bip_top bip_top_chk u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .nmi_in(nmi_in),
  .cpu_inta(cpu_inta), .cpu_intr(cpu_intr), .cpu_nmi(cpu_nmi),
  .cpu_vector(cpu_vector));
`default_nettype wire

// *** test/bip_top_tb.sv ***
/*
  Self-checking bench of bip_top: APB register access, the four modes,
  edge latch, cascade, flag byte, fail-safe, OR matrix and NMI.
  Assumes bip_cpu_model as the CPU and a short fail-safe count.
*/
`default_nettype none
module bip_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FS = 20;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, er, en;
  logic [7:0] paddr, cpu_vector, acks, serial_irq;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] bus_irq, dma_irq;
  logic [2:0] timer_irq;
  logic [3:0] exp_irq, aux_irq, or_irq, dly;
  logic lan_irq, systick_irq, edge_irq, bus_flag_set, bus_flag_clr;
  logic bus_cmd_start, bus_cmd_done, nmi_in, cpu_inta, cpu_intr, cpu_nmi;
  int fails = 0;
  int total_checks = 0;
  logic [7:0] ra [8] = '{8'h00, 8'h04, 8'h08, 8'h18, 8'h28, 8'h2C, 8'h30,
    8'h34};
  logic [31:0] rv [8] = '{32'h00002070, 32'h000000FF, 32'h00000000,
    32'h0000001F, 32'hFEDCBA98, 32'hFEDCBA98, 32'hFEDCBA98, 32'hFEDCBA98};

  always #4 pclk = ~pclk;

  bip_top #(.FAILSAFE_CYCLES(FS), .OR_WIDTH(4)) dut (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bus_irq(bus_irq), .serial_irq(serial_irq),
    .timer_irq(timer_irq), .dma_irq(dma_irq), .lan_irq(lan_irq),
    .systick_irq(systick_irq), .exp_irq(exp_irq), .aux_irq(aux_irq),
    .edge_irq(edge_irq), .or_irq(or_irq), .bus_flag_set(bus_flag_set),
    .bus_flag_clr(bus_flag_clr), .bus_cmd_start(bus_cmd_start),
    .bus_cmd_done(bus_cmd_done), .nmi_in(nmi_in), .cpu_inta(cpu_inta),
    .cpu_intr(cpu_intr), .cpu_nmi(cpu_nmi), .cpu_vector(cpu_vector));

  bip_cpu_model cpu (.pclk(pclk), .presetn(presetn), .en(en), .dly(dly),
    .cpu_intr(cpu_intr), .cpu_inta(cpu_inta), .acks(acks));

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s,
    input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, s);
      fails++;
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      chk("pready", 32'(pready), 32'h1);
      conclude();
    end else begin
      // Idle edge, so a strobe is never set twice in one step
      @(posedge pclk);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a,
    input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, e);
  endtask

  // Wait for the model's next acknowledge, then compare the vector
  task automatic ack(input logic [7:0] ev);
    int n;
    logic [7:0] a0;
    a0 = acks;
    n = 0;
    while (acks === a0 && n < 60) begin
      @(posedge pclk);
      n++;
    end
    if (acks === a0) begin
      chk("ack", 32'h0, 32'h1);
      conclude();
    end else begin
      cyc(2);
      chk("vector", 32'(cpu_vector), 32'(ev));
    end
  endtask

  task automatic rst();
    presetn <= 1'b0;
    cyc(3);
    presetn <= 1'b1;
  endtask

  task automatic t_regs();
    for (int i = 0; i < 8; i++) rdc("reset value", ra[i], rv[i]);
    rdc("unmapped", 8'h40, 32'h0);
    chk("unmapped err", 32'(er), 32'h1);
    wr(8'h10, 32'hFFFFFFFF);
    chk("ro err", 32'(er), 32'h0);
    $display("register test done");
  endtask

  task automatic t_nested();
    wr(8'h04, 32'h0);
    en <= 1'b1;
    bus_irq <= 2'h2;
    exp_irq <= 4'h1;
    ack(8'h21);
    bus_irq <= 2'h0;
    cyc(4);
    chk("intr blocked", 32'(cpu_intr), 32'h0);
    wr(8'h0C, 32'h0);
    ack(8'h27);
    exp_irq <= 4'h0;
    wr(8'h0C, 32'h0);
    $display("nested test done");
  endtask

  task automatic t_edge();
    wr(8'h08, 32'h04);
    serial_irq <= 8'h01;
    cyc(1);
    serial_irq <= 8'h00;
    ack(8'h22);
    wr(8'h0C, 32'h0);
    cyc(4);
    chk("edge cleared", 32'(cpu_intr), 32'h0);
    wr(8'h08, 32'h0);
    $display("edge test done");
  endtask

  task automatic t_specific();
    dly <= 4'h0;
    wr(8'h00, 32'h00002032);
    bus_irq <= 2'h1;
    aux_irq <= 4'h1;
    ack(8'h25);
    aux_irq <= 4'h0;
    wr(8'h0C, 32'h0);
    ack(8'h20);
    bus_irq <= 2'h0;
    wr(8'h0C, 32'h0);
    $display("specific test done");
  endtask

  task automatic t_polled();
    rst();
    en <= 1'b0;
    wr(8'h04, 32'h0);
    wr(8'h00, 32'h00002073);
    serial_irq <= 8'h14;
    cyc(3);
    rdc("poll", 8'h14, 32'h84);
    chk("polled intr", 32'(cpu_intr), 32'h0);
    rdc("status", 8'h10, 32'h00001050);
    wr(8'h0C, 32'h0);
    serial_irq <= 8'h10;
    cyc(2);
    rdc("poll next", 8'h14, 32'h86);
    serial_irq <= 8'h00;
    wr(8'h0C, 32'h0);
    cyc(2);
    apb(1'b0, 8'h14, 32'h0);
    chk("poll empty", rd & 32'h80, 32'h0);
    $display("polled test done");
  endtask

  task automatic t_cascade();
    rst();
    wr(8'h18, 32'h0);
    wr(8'h04, 32'hFB);
    wr(8'h00, 32'h00002071);
    en <= 1'b1;
    timer_irq <= 3'h2;
    dma_irq <= 2'h1;
    ack(8'h22);
    ack(8'h22);
    en <= 1'b0;
    rdc("slave pend", 8'h1C, 32'h0A);
    timer_irq <= 3'h0;
    dma_irq <= 2'h0;
    wr(8'h1C, 32'h02);
    rdc("slave w1c", 8'h1C, 32'h08);
    $display("cascade test done");
  endtask

  task automatic t_misc();
    rst();
    nmi_in <= 1'b1;
    cyc(2);
    chk("nmi", 32'(cpu_nmi), 32'h1);
    nmi_in <= 1'b0;
    bus_flag_set <= 1'b1;
    cyc(1);
    bus_flag_set <= 1'b0;
    rdc("flag set", 8'h20, 32'h1);
    bus_flag_clr <= 1'b1;
    cyc(1);
    bus_flag_clr <= 1'b0;
    rdc("flag clr", 8'h20, 32'h0);
    edge_irq <= 1'b1;
    cyc(1);
    edge_irq <= 1'b0;
    rdc("edge held", 8'h20, 32'h2);
    wr(8'h20, 32'h2);
    bus_cmd_start <= 1'b1;
    cyc(1);
    bus_cmd_start <= 1'b0;
    cyc(FS - 6);
    rdc("fs early", 8'h20, 32'h0);
    cyc(6);
    rdc("fs late", 8'h20, 32'h4);
    wr(8'h04, 32'hEF);
    en <= 1'b1;
    or_irq <= 4'h4;
    ack(8'h24);
    or_irq <= 4'h0;
    $display("misc test done");
  endtask

  // Inputs idle at time zero, reset held for ten cycles
  initial begin
    {psel, penable, pwrite, lan_irq, systick_irq, edge_irq} = 6'h00;
    {bus_flag_set, bus_flag_clr, bus_cmd_start, bus_cmd_done} = 4'h0;
    {nmi_in, en, paddr, pwdata, serial_irq} = 50'h0;
    {bus_irq, dma_irq, timer_irq, exp_irq, aux_irq, or_irq} = 19'h0;
    dly = 4'h3;
    cyc(10);
    presetn <= 1'b1;
    t_regs();
    t_nested();
    t_edge();
    t_specific();
    t_polled();
    t_cascade();
    t_misc();
    conclude();
  end
endmodule // bip_top_tb
`default_nettype wire
